// ---- include/aic_pkg.sv ----
// Package with register map, field positions and reset values of the channel processor.
`default_nettype none
package aic_pkg;
  localparam int unsigned AIC_NCH = 8;
  localparam int unsigned AIC_CHW = 3;
  localparam logic [11:0] AIC_RAW_MAX = 12'hFFF;
  localparam logic [11:0] AIC_RAW_4MA = 12'h333;
  localparam int unsigned AIC_SPAN_BYTES = 256;
  localparam logic [11:0] AIC_OFS_CTRL = 12'h000;
  localparam logic [11:0] AIC_OFS_ACTIVE = 12'h004;
  localparam logic [11:0] AIC_OFS_REPORT = 12'h008;
  localparam logic [11:0] AIC_OFS_RANGE = 12'h00C;
  localparam logic [11:0] AIC_OFS_FAULT = 12'h010;
  localparam logic [11:0] AIC_OFS_FAULT_CLR = 12'h014;
  localparam logic [11:0] AIC_OFS_IRQ_STAT = 12'h018;
  localparam logic [11:0] AIC_OFS_IRQ_CLR = 12'h01C;
  localparam logic [11:0] AIC_OFS_IRQ_EN = 12'h020;
  localparam logic [11:0] AIC_OFS_REF_START = 12'h024;
  localparam logic [11:0] AIC_OFS_STATUS = 12'h028;
  localparam logic [3:0] AIC_CH_REGION = 4'h1;
  localparam logic [2:0] AIC_CH_SL = 3'h0;
  localparam logic [2:0] AIC_CH_SH = 3'h1;
  localparam logic [2:0] AIC_CH_RL = 3'h2;
  localparam logic [2:0] AIC_CH_RH = 3'h3;
  localparam logic [2:0] AIC_CH_ALO = 3'h4;
  localparam logic [2:0] AIC_CH_AHI = 3'h5;
  localparam logic [2:0] AIC_CH_VAL = 3'h6;
  localparam int unsigned AIC_CTRL_HOLD = 0;
  localparam int unsigned AIC_IRQ_FAULT = 0;
  localparam int unsigned AIC_IRQ_LOST = 1;
  localparam logic [15:0] AIC_RST_ALO = 16'h8001;
  localparam logic [15:0] AIC_RST_AHI = 16'h7FFF;
  localparam logic [15:0] AIC_RST_REF = 16'h0000;
  typedef enum logic [2:0] {
    AIC_CAUSE_NONE = 3'b000,
    AIC_CAUSE_LOW = 3'b001,
    AIC_CAUSE_HIGH = 3'b010,
    AIC_CAUSE_UNDER = 3'b011,
    AIC_CAUSE_MODULE = 3'b100
  } aic_cause_e;
endpackage
`default_nettype wire

// ---- rtl/aic_channel_proc.sv ----
// Analog input channel processor: scaling, alarms, fault reports and APB registers.
// How it works
// - Enabled channel faults queue a controller message.
// - Report-disabled channels never queue messages.
// - Faults latch regardless of report enable.
// - Active channel samples are scaled and checked.
// - Inactive channel samples dropped, no faults.
// - Per-channel range bit selects 4-20 mA.
// - Raw samples are unsigned 12 bits.
// - Two point pairs configure linear scaling.
// - Unconfigured channels pass raw value through.
// - Low and high alarms compare scaled value.
// - Alarm after clear only beyond new threshold.
// - Hold-last keeps values when data stops.
// - Otherwise values are zeroed when data stops.
// - Channel table fits one 256-byte span.
// - References assigned from start address onward.
`timescale 1ns/100ps
`default_nettype none
module aic_channel_proc #(
  parameter int unsigned NCH = aic_pkg::AIC_NCH,
  parameter int unsigned CHW = aic_pkg::AIC_CHW
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic raw_valid,
  input wire logic [CHW-1:0] raw_chan,
  input wire logic [11:0] raw_value,
  input wire logic [NCH-1:0] module_chan_fault,
  input wire logic module_data_lost,
  output logic out_valid,
  output logic [CHW-1:0] out_chan,
  output logic [15:0] out_value,
  output logic [15:0] out_ref,
  output logic fault_msg_valid,
  input wire logic fault_msg_ready,
  output logic [CHW-1:0] fault_msg_chan,
  output logic [2:0] fault_msg_cause,
  output logic irq
);
  import aic_pkg::*;

  // The table must fit in the span reserved for analog inputs.
  // An oversize table stops elaboration instead of aliasing channel slots.
  if (NCH * 2 > AIC_SPAN_BYTES || NCH > 8) begin : g_bad_span
    $error("channel table does not fit its span");
  end

  logic hold_r;
  logic [NCH-1:0] active_r, report_r, range_r, fault_r, pend_r, cfg_r;
  logic [1:0] irq_stat_r, irq_en_r;
  logic [15:0] ref_r;
  logic lost_r;
  logic signed [15:0] sl_r [NCH];
  logic signed [15:0] sh_r [NCH];
  logic [11:0] rl_r [NCH];
  logic [11:0] rh_r [NCH];
  logic signed [15:0] alo_r [NCH];
  logic signed [15:0] ahi_r [NCH];
  logic [15:0] val_r [NCH];
  logic [2:0] cause_r [NCH];
  logic out_valid_r;
  logic [CHW-1:0] out_chan_r;
  logic [15:0] out_value_r, out_ref_r;

  // APB decode; the slave answers in the access cycle with no wait states.
  wire wr = psel & penable & pwrite & ce;
  wire in_ch = (paddr[11:8] == AIC_CH_REGION);
  wire [CHW-1:0] a_ch = paddr[5+CHW-1:5];
  wire [2:0] a_off = paddr[4:2];
  // Slots past the last channel answer with an error, so software sees a short table.
  wire ch_ok = in_ch && (32'(a_ch) < NCH) && (32'(paddr[7:5]) < NCH) && (a_off <= AIC_CH_VAL);
  wire glob_ok = (paddr <= AIC_OFS_STATUS) && (paddr[1:0] == 2'b00);
  wire hit = ch_ok || glob_ok;
  wire full = (pstrb == 4'hF);
  wire wr_g = wr & full & glob_ok;
  wire wr_ctrl = wr_g && (paddr == AIC_OFS_CTRL);
  wire wr_act = wr_g && (paddr == AIC_OFS_ACTIVE);
  wire wr_rep = wr_g && (paddr == AIC_OFS_REPORT);
  wire wr_rng = wr_g && (paddr == AIC_OFS_RANGE);
  wire wr_fclr = wr_g && (paddr == AIC_OFS_FAULT_CLR);
  wire wr_iclr = wr_g && (paddr == AIC_OFS_IRQ_CLR);
  wire wr_ien = wr_g && (paddr == AIC_OFS_IRQ_EN);
  wire wr_ref = wr_g && (paddr == AIC_OFS_REF_START);
  wire wr_c = wr & full & ch_ok & in_ch;

  // Sample acceptance, scaling and fault detection for the sample's channel.
  wire go = ce & raw_valid & active_r[raw_chan];
  wire signed [15:0] scaled;
  wire signed [33:0] s_den = 34'($signed({22'h0, rh_r[raw_chan]}))
                           - 34'($signed({22'h0, rl_r[raw_chan]}));
  wire signed [33:0] s_num = (34'($signed({22'h0, raw_value}))
                           - 34'($signed({22'h0, rl_r[raw_chan]})))
                           * (34'(sh_r[raw_chan]) - 34'(sl_r[raw_chan]));
  wire signed [33:0] s_quo = (s_den == 34'sh0) ? 34'sh0 : s_num / s_den;
  wire signed [33:0] s_sum = s_quo + 34'(sl_r[raw_chan]);
  wire s_unity = !cfg_r[raw_chan] || (s_den == 34'sh0);
  assign scaled = s_unity ? $signed({4'h0, raw_value}) :
                  (s_sum > 34'sd32767) ? 16'sh7FFF :
                  (s_sum < -34'sd32768) ? 16'sh8000 : s_sum[15:0];
  // Thresholds are read live, so after a clear only the current limit can trip.
  wire f_low = scaled < alo_r[raw_chan];
  wire f_high = scaled > ahi_r[raw_chan];
  wire f_under = range_r[raw_chan] && (raw_value < AIC_RAW_4MA);
  wire f_mod = module_chan_fault[raw_chan];
  wire f_any = go & (f_low | f_high | f_under | f_mod);
  wire [2:0] f_cause = f_mod ? AIC_CAUSE_MODULE : f_under ? AIC_CAUSE_UNDER :
                       f_high ? AIC_CAUSE_HIGH : f_low ? AIC_CAUSE_LOW : AIC_CAUSE_NONE;
  wire f_new = f_any & ~fault_r[raw_chan];
  wire lost_rise = module_data_lost & ~lost_r;

  // Lowest pending channel is offered first; the controller can stall it.
  logic [CHW-1:0] msg_ch;
  always_comb begin
    msg_ch = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (pend_r[i]) begin
        msg_ch = CHW'(i);
      end
    end
  end
  wire msg_take = ce & fault_msg_valid & fault_msg_ready;

  genvar g;
  for (g = 0; g < NCH; g++) begin : g_ch
    wire sel = wr_c && (a_ch == CHW'(g));
    wire smp = go && (raw_chan == CHW'(g));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sl_r[g] <= 16'sh0000;
        sh_r[g] <= 16'sh0000;
        rl_r[g] <= 12'h000;
        rh_r[g] <= 12'h000;
        alo_r[g] <= AIC_RST_ALO;
        ahi_r[g] <= AIC_RST_AHI;
        cfg_r[g] <= 1'b0;
      end else begin
        if (sel && a_off == AIC_CH_SL) sl_r[g] <= pwdata[15:0];
        if (sel && a_off == AIC_CH_SH) sh_r[g] <= pwdata[15:0];
        if (sel && a_off == AIC_CH_RL) rl_r[g] <= pwdata[11:0];
        if (sel && a_off == AIC_CH_RH) rh_r[g] <= pwdata[11:0];
        if (sel && a_off == AIC_CH_ALO) alo_r[g] <= pwdata[15:0];
        if (sel && a_off == AIC_CH_AHI) ahi_r[g] <= pwdata[15:0];
        if (sel && a_off <= AIC_CH_RH) cfg_r[g] <= 1'b1;
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        val_r[g] <= 16'h0000;
        fault_r[g] <= 1'b0;
        pend_r[g] <= 1'b0;
        cause_r[g] <= AIC_CAUSE_NONE;
      end else if (ce) begin
        if (module_data_lost && !hold_r) begin
          val_r[g] <= 16'h0000;
        end else if (smp && !module_data_lost) begin
          val_r[g] <= scaled;
        end
        // A fault still present in the clearing cycle stays latched.
        if (smp && f_any) begin
          fault_r[g] <= 1'b1;
          if (!fault_r[g]) cause_r[g] <= f_cause;
        end else if (wr_fclr && pwdata[g]) begin
          fault_r[g] <= 1'b0;
        end
        if (smp && f_new && report_r[g]) begin
          pend_r[g] <= 1'b1;
        end else if (msg_take && msg_ch == CHW'(g)) begin
          pend_r[g] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r <= 1'b0;
      active_r <= '0;
      report_r <= '0;
      range_r <= '0;
      irq_en_r <= 2'h0;
      ref_r <= AIC_RST_REF;
      lost_r <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) hold_r <= pwdata[AIC_CTRL_HOLD];
      if (wr_act) active_r <= pwdata[NCH-1:0];
      if (wr_rep) report_r <= pwdata[NCH-1:0];
      if (wr_rng) range_r <= pwdata[NCH-1:0];
      if (wr_ien) irq_en_r <= pwdata[1:0];
      if (wr_ref) ref_r <= pwdata[15:0];
      lost_r <= module_data_lost;
    end
  end

  // Status bits: a new event in the clearing cycle survives the clear.
  wire [1:0] irq_set = {lost_rise, f_new};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= 2'h0;
    end else if (ce) begin
      irq_stat_r <= irq_set | (irq_stat_r & ~(wr_iclr ? pwdata[1:0] : 2'h0));
    end
  end
  assign irq = |(irq_stat_r & irq_en_r);

  // Result stage toward the network controller.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid_r <= 1'b0;
      out_chan_r <= '0;
      out_value_r <= 16'h0000;
      out_ref_r <= 16'h0000;
    end else if (ce) begin
      out_valid_r <= go & ~module_data_lost;
      if (go) begin
        out_chan_r <= raw_chan;
        out_value_r <= scaled;
        out_ref_r <= ref_r + 16'(raw_chan);
      end
    end
  end
  assign out_valid = out_valid_r;
  assign out_chan = out_chan_r;
  assign out_value = out_value_r;
  assign out_ref = out_ref_r;
  assign fault_msg_valid = |pend_r;
  assign fault_msg_chan = msg_ch;
  assign fault_msg_cause = cause_r[msg_ch];

  // Read mux; write-only registers and reserved global bits read as zero; 16-bit channel registers are sign-extended.
  wire [31:0] rd_ch = (a_off == AIC_CH_SL) ? 32'($signed(sl_r[a_ch])) :
                      (a_off == AIC_CH_SH) ? 32'($signed(sh_r[a_ch])) :
                      (a_off == AIC_CH_RL) ? {20'h0, rl_r[a_ch]} :
                      (a_off == AIC_CH_RH) ? {20'h0, rh_r[a_ch]} :
                      (a_off == AIC_CH_ALO) ? 32'($signed(alo_r[a_ch])) :
                      (a_off == AIC_CH_AHI) ? 32'($signed(ahi_r[a_ch])) :
                      32'($signed(val_r[a_ch]));
  wire [31:0] rd_g = (paddr == AIC_OFS_CTRL) ? {31'h0, hold_r} :
                     (paddr == AIC_OFS_ACTIVE) ? 32'(active_r) :
                     (paddr == AIC_OFS_REPORT) ? 32'(report_r) :
                     (paddr == AIC_OFS_RANGE) ? 32'(range_r) :
                     (paddr == AIC_OFS_FAULT) ? 32'(fault_r) :
                     (paddr == AIC_OFS_IRQ_STAT) ? {30'h0, irq_stat_r} :
                     (paddr == AIC_OFS_IRQ_EN) ? {30'h0, irq_en_r} :
                     (paddr == AIC_OFS_REF_START) ? {16'h0, ref_r} :
                     (paddr == AIC_OFS_STATUS) ? {31'h0, module_data_lost} : 32'h0;
  assign prdata = !(psel & penable & ~pwrite) ? 32'h0 :
                  ch_ok ? rd_ch : glob_ok ? rd_g : 32'h0;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  a_inactive_drop: assert property (@(posedge pclk) disable iff (!presetn)
    ce && raw_valid && !active_r[raw_chan] && !fault_r[raw_chan]
    |=> !fault_r[$past(raw_chan)])
    else $error("inactive channel raised a fault");
  a_inactive_out: assert property (@(posedge pclk) disable iff (!presetn)
    ce && raw_valid && !active_r[raw_chan] |=> !out_valid)
    else $error("inactive channel produced data");
  a_report_gate: assert property (@(posedge pclk) disable iff (!presetn)
    ce && f_new && !report_r[raw_chan] && !pend_r[raw_chan] |=> !pend_r[$past(raw_chan)])
    else $error("message queued for report-disabled channel");
  a_report_set: assert property (@(posedge pclk) disable iff (!presetn)
    ce && f_new && report_r[raw_chan] |=> fault_msg_valid ##0 pend_r[$past(raw_chan)])
    else $error("enabled fault not queued");
  a_fault_latch: assert property (@(posedge pclk) disable iff (!presetn)
    ce && f_any |=> fault_r[$past(raw_chan)])
    else $error("detected fault not latched");
  a_unity_pass: assert property (@(posedge pclk) disable iff (!presetn)
    go && !cfg_r[raw_chan] |=> out_value == {4'h0, $past(raw_value)})
    else $error("unconfigured channel not unity scaled");
  a_zero_fill: assert property (@(posedge pclk) disable iff (!presetn)
    ce && module_data_lost && !hold_r |=> val_r[0] == 16'h0000)
    else $error("values not zeroed on data loss");
  a_hold_last: assert property (@(posedge pclk) disable iff (!presetn)
    ce && module_data_lost && hold_r |=> $stable(val_r[0]))
    else $error("held value changed during data loss");
  a_alarm_high: assert property (@(posedge pclk) disable iff (!presetn)
    go && scaled > ahi_r[raw_chan] && !fault_r[raw_chan] |=> fault_r[$past(raw_chan)]
    ##0 cause_r[$past(raw_chan)] != AIC_CAUSE_NONE)
    else $error("high alarm missed");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_iclr && irq_set == 2'h0 && (pwdata[1:0] | ~irq_en_r) == 2'h3 |=> !irq)
    else $error("interrupt still high after clear");

  // Further checks on scan, alarms, messages and data loss.
  a_alarm_low: assert property (@(posedge pclk) disable iff (!presetn)
    go && scaled < alo_r[raw_chan] |=> fault_r[$past(raw_chan)])
    else $error("low alarm missed");
  a_range_under: assert property (@(posedge pclk) disable iff (!presetn)
    go && range_r[raw_chan] && raw_value < AIC_RAW_4MA |=> fault_r[$past(raw_chan)])
    else $error("under-range current not latched");
  a_under_cause: assert property (@(posedge pclk) disable iff (!presetn)
    go && f_under && !f_mod && !fault_r[raw_chan] |=> cause_r[$past(raw_chan)] == AIC_CAUSE_UNDER)
    else $error("under-range cause wrong");
  a_module_cause: assert property (@(posedge pclk) disable iff (!presetn)
    go && f_mod && !fault_r[raw_chan] |=> cause_r[$past(raw_chan)] == AIC_CAUSE_MODULE)
    else $error("module fault cause wrong");
  a_active_data: assert property (@(posedge pclk) disable iff (!presetn)
    go && !module_data_lost |=> out_valid && out_chan == $past(raw_chan))
    else $error("active channel sample not delivered");
  a_inactive_keep: assert property (@(posedge pclk) disable iff (!presetn)
    ce && raw_valid && !active_r[raw_chan] |=> $stable(out_value))
    else $error("inactive channel changed the result");
  a_ref_assign: assert property (@(posedge pclk) disable iff (!presetn)
    go |=> out_ref == $past(ref_r) + 16'($past(raw_chan)))
    else $error("reference not start plus channel");
  a_msg_lowest: assert property (@(posedge pclk) disable iff (!presetn)
    fault_msg_valid |-> pend_r[fault_msg_chan]
    && (pend_r & ~({NCH{1'b1}} << fault_msg_chan)) == '0)
    else $error("offered message not lowest pending channel");
  a_lost_no_out: assert property (@(posedge pclk) disable iff (!presetn)
    ce && module_data_lost |=> !out_valid)
    else $error("result delivered during data loss");
  a_hold_last_hi: assert property (@(posedge pclk) disable iff (!presetn)
    ce && module_data_lost && hold_r |=> $stable(val_r[NCH-1]))
    else $error("held value of last channel changed");
  a_zero_fill_hi: assert property (@(posedge pclk) disable iff (!presetn)
    ce && module_data_lost && !hold_r |=> val_r[NCH-1] == 16'h0000)
    else $error("last channel not zeroed on data loss");
  a_lost_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ce && lost_rise |=> irq_stat_r[AIC_IRQ_LOST])
    else $error("data loss status not set");
  a_ce_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    !ce |=> $stable(fault_r) && $stable(pend_r) && $stable(irq_stat_r))
    else $error("state changed with clock enable low");
  c_fault_msg: cover property (@(posedge pclk) disable iff (!presetn) msg_take);
  c_scaled_out: cover property (@(posedge pclk) disable iff (!presetn)
    out_valid && cfg_r[out_chan]);
  c_data_lost: cover property (@(posedge pclk) disable iff (!presetn) lost_rise && hold_r);
  c_under_range: cover property (@(posedge pclk) disable iff (!presetn) go && f_under);
  c_clear_refault: cover property (@(posedge pclk) disable iff (!presetn)
    wr_fclr ##[1:20] f_new);
endmodule
`default_nettype wire

// ---- verif/aic_net_model.sv ----
// Behavioural network controller that takes fault messages and can stall them.
`timescale 1ns/100ps
`default_nettype none
module aic_net_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall,
  input wire logic fault_msg_valid,
  input wire logic [2:0] fault_msg_chan,
  input wire logic [2:0] fault_msg_cause,
  output logic fault_msg_ready,
  output var int msg_count,
  output logic [2:0] last_chan,
  output logic [2:0] last_cause
);
  // Ready is registered, so a stall lasts at least one whole cycle as on a busy controller.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_msg_ready <= 1'b0;
      msg_count <= 0;
      last_chan <= 3'h0;
      last_cause <= 3'h0;
    end else begin
      fault_msg_ready <= !stall;
      if (fault_msg_valid && fault_msg_ready) begin
        msg_count <= msg_count + 1;
        last_chan <= fault_msg_chan;
        last_cause <= fault_msg_cause;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the channel processor.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import aic_pkg::*;
  typedef struct packed {logic [2:0] ch; logic [11:0] raw; logic [15:0] val;} aic_row_s;
  logic pclk, presetn, psel, penable, pwrite, raw_valid, module_data_lost, stall, ce;
  logic pready, pslverr, out_valid, fault_msg_valid, fault_msg_ready, irq, err, seen;
  logic [11:0] paddr, raw_value;
  logic [31:0] pwdata, prdata, rdat;
  logic [2:0] raw_chan, out_chan, fault_msg_chan, fault_msg_cause, last_chan, last_cause;
  logic [7:0] module_chan_fault;
  logic [15:0] out_value, out_ref;
  int fails, n_tests, msg_count, k;
  aic_row_s rows [5] = '{'{3'h1, 12'h000, 16'h0000}, '{3'h1, 12'hFFF, 16'h03E8},
    '{3'h1, 12'h800, 16'h01F4}, '{3'h1, 12'h064, 16'h0018}, '{3'h0, 12'hFFF, 16'h0FFF}};
  aic_channel_proc i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .raw_valid(raw_valid),
    .raw_chan(raw_chan), .raw_value(raw_value), .module_chan_fault(module_chan_fault),
    .module_data_lost(module_data_lost), .out_valid(out_valid), .out_chan(out_chan),
    .out_value(out_value), .out_ref(out_ref), .fault_msg_valid(fault_msg_valid),
    .fault_msg_ready(fault_msg_ready), .fault_msg_chan(fault_msg_chan),
    .fault_msg_cause(fault_msg_cause), .irq(irq));
  aic_net_model i_net (.pclk(pclk), .presetn(presetn), .stall(stall),
    .fault_msg_valid(fault_msg_valid), .fault_msg_chan(fault_msg_chan),
    .fault_msg_cause(fault_msg_cause), .fault_msg_ready(fault_msg_ready),
    .msg_count(msg_count), .last_chan(last_chan), .last_cause(last_cause));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [11:0] ca(input logic [2:0] ch, input logic [2:0] f);
    return {AIC_CH_REGION, ch, f, 2'b00};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // The request stays put until pready is seen high; after 16 cycles without it the bench counts a failure and stops.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 16) begin
      fails++;
      results();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task automatic rd(input logic [11:0] a); apb(1'b0, a, 32'h0); endtask
  task automatic smp(input logic [2:0] ch, input logic [11:0] raw);
    @(posedge pclk);
    raw_valid <= 1'b1;
    raw_chan <= ch;
    raw_value <= raw;
    @(posedge pclk);
    raw_valid <= 1'b0;
    #1 seen = out_valid;
  endtask
  task automatic wmsg(input int n);
    for (k = 0; k < 20 && msg_count != n; k++) @(posedge pclk);
    #1;
    if (msg_count != n) begin
      fails++;
      results();
    end
  endtask
  initial begin
    {presetn, psel, penable, pwrite, raw_valid, module_data_lost, stall} = 7'h00;
    ce = 1'b1;
    {paddr, raw_value, raw_chan, module_chan_fault} = 35'h0;
    pwdata = 32'h0;
    fails = 0;
    n_tests = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(ca(3'h1, AIC_CH_ALO));
    chk("alarm_low_reset", 32'hFFFF8001, rdat);
    chk("irq_reset", 32'h0, {31'h0, irq});
    $display("test reset done");
    wr(AIC_OFS_REF_START, 32'h00000040);
    wr(AIC_OFS_ACTIVE, 32'h0000000B);
    wr(AIC_OFS_REPORT, 32'h0000000A);
    wr(AIC_OFS_RANGE, 32'h00000008);
    wr(AIC_OFS_IRQ_EN, 32'h00000001);
    wr(AIC_OFS_CTRL, 32'h00000001);
    wr(ca(3'h1, AIC_CH_SL), 32'h0);
    wr(ca(3'h1, AIC_CH_SH), 32'h3E8);
    wr(ca(3'h1, AIC_CH_RL), 32'h0);
    wr(ca(3'h1, AIC_CH_RH), 32'hFFF);
    foreach (rows[i]) begin
      smp(rows[i].ch, rows[i].raw);
      chk("out_valid", 32'h1, {31'h0, seen});
      chk("out_chan", {29'h0, rows[i].ch}, {29'h0, out_chan});
      chk("out_value", {16'h0, rows[i].val}, {16'h0, out_value});
      chk("out_ref", 32'h40 + rows[i].ch, {16'h0, out_ref});
    end
    $display("test scaling table done");
    smp(3'h2, 12'h800);
    chk("inactive_valid", 32'h0, {31'h0, seen});
    stall <= 1'b1;
    wr(ca(3'h1, AIC_CH_AHI), 32'h384);
    smp(3'h1, 12'hFFF);
    cyc(4);
    chk("msg_while_stalled", 32'h0, msg_count);
    stall <= 1'b0;
    wmsg(1);
    chk("msg_chan", 32'h1, {29'h0, last_chan});
    chk("msg_cause", {29'h0, AIC_CAUSE_HIGH}, {29'h0, last_cause});
    chk("irq_set", 32'h1, {31'h0, irq});
    wr(AIC_OFS_IRQ_CLR, 32'h1);
    cyc(1);
    chk("irq_clear", 32'h0, {31'h0, irq});
    wr(ca(3'h1, AIC_CH_AHI), 32'h44C);
    wr(AIC_OFS_FAULT_CLR, 32'h2);
    smp(3'h1, 12'hFFF);
    cyc(4);
    chk("no_msg_new_limit", 32'h1, msg_count);
    wr(ca(3'h1, AIC_CH_AHI), 32'h3E7);
    smp(3'h1, 12'hFFF);
    wmsg(2);
    chk("msg_past_new_limit", {29'h0, AIC_CAUSE_HIGH}, {29'h0, last_cause});
    $display("test alarms done");
    wr(AIC_OFS_IRQ_EN, 32'h0);
    wr(ca(3'h0, AIC_CH_ALO), 32'h200);
    module_chan_fault <= 8'h01;
    smp(3'h0, 12'h100);
    @(posedge pclk);
    module_chan_fault <= 8'h00;
    smp(3'h3, 12'h100);
    wmsg(3);
    chk("under_chan", 32'h3, {29'h0, last_chan});
    chk("under_cause", {29'h0, AIC_CAUSE_UNDER}, {29'h0, last_cause});
    chk("irq_masked", 32'h0, {31'h0, irq});
    rd(AIC_OFS_IRQ_STAT);
    chk("irq_stat", 32'h1, rdat);
    rd(AIC_OFS_FAULT);
    chk("fault_latch", 32'hB, rdat);
    chk("msg_unreported", 32'h3, msg_count);
    $display("test faults done");
    module_data_lost <= 1'b1;
    smp(3'h1, 12'h000);
    chk("lost_valid", 32'h0, {31'h0, seen});
    rd(ca(3'h1, AIC_CH_VAL));
    chk("hold_value", 32'h3E8, rdat);
    wr(AIC_OFS_CTRL, 32'h0);
    cyc(2);
    rd(ca(3'h1, AIC_CH_VAL));
    chk("zero_value", 32'h0, rdat);
    ce <= 1'b0;
    wr(AIC_OFS_REF_START, 32'h00000080);
    ce <= 1'b1;
    rd(AIC_OFS_REF_START);
    chk("ce_freeze", 32'h40, rdat);
    rd(12'h0FC);
    chk("unmapped_err", 32'h1, {31'h0, err});
    $display("test data loss done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(AIC_OFS_FAULT);
    chk("fault_reset", 32'h0, rdat);
    chk("msg_valid_reset", 32'h0, {31'h0, fault_msg_valid});
    $display("test mid-run reset done");
    results();
  end
endmodule
`default_nettype wire
